// ---- dmi_bus_sensor.v ----
// Downstream bus sensor: busy between a START and a STOP
`timescale 1ns/1ps
module dmi_bus_sensor (
  input  wire sys_clk, // System clock
  input  wire reset_n, // Asynchronous reset, active low
  input  wire scl,     // Synchronised downstream clock line
  input  wire sda,     // Synchronised downstream data line
  output reg  busy     // Transfer in progress downstream
);

  reg scl_prev;
  reg sda_prev;

  wire start_seen = scl & scl_prev & sda_prev & ~sda;
  wire stop_seen  = scl & scl_prev & ~sda_prev & sda;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      busy     <= 1'b0;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
      if (start_seen) begin
        busy <= 1'b1;
      end else if (stop_seen) begin
        busy <= 1'b0;
      end
    end
  end

endmodule // dmi_bus_sensor

// ---- dmi_consts.vh ----
// Constants for the dual master interrupt logic
`ifndef DMI_CONSTS_VH
`define DMI_CONSTS_VH

// Upstream slave address: fixed prefix plus four address pins
`define DMI_ADDR_PREFIX   3'b111
`define DMI_ADDR_PINS     4

// Register select field of the command byte
`define DMI_SEL_LSB       0
`define DMI_SEL_MSB       1
`define DMI_REG_STATUS    2'b10

// Interrupt status register bit positions
`define DMI_BIT_PEER_TEST 7
`define DMI_BIT_SELF_TEST 6
`define DMI_BIT_LOST      3
`define DMI_BIT_UNCLEAN   2
`define DMI_BIT_RDONE     1
`define DMI_BIT_DS_IRQ    0
`define DMI_STATUS_RESET  8'h00

// Serial byte framing
`define DMI_BITS_PER_BYTE 4'h8
`define DMI_CLEAR_PULSE   4'h1

// Synchroniser layout
`define DMI_SYNC_WIDTH    11
`define DMI_SYNC_RESET    11'h7ff

`endif

// ---- dmi_irq_logic.v ----
// Interrupt logic and status read port of the dual master bus selector
//
// Contract
// - Losing master's interrupt goes low once it is disconnected downstream.
// - Lost-control mask bit 1 keeps the losing master's interrupt released.
// - Recovery request set; new master interrupted once downstream recovery ends.
// - Recovery-done mask bit 1 suppresses the recovery completion interrupt.
// - Without recovery, switch during START..STOP interrupts the new master.
// - Bus-sensor mask bit 1 suppresses the unclean-switch interrupt.
// - Unclean-switch flag stays clear when recovery was requested.
// - Unmasked low downstream input drives both interrupt outputs low.
// - Downstream mask blocks only its own master's output.
// - Self-test request 1 pulls the same master's interrupt low.
// - Peer-test request 1 pulls the other master's interrupt low.
// - Writing a test request back to 0 releases its interrupt.
// - Interrupt outputs are open-drain: low when active, released otherwise.
// - Two status registers; each master reads its own.
// - Status register is selected by register select value binary 10.
// - Bit 7 reads the other master's peer-test request.
// - Bit 6 reads this master's own self-test request.
// - Bit 3 set in previous master's register when switch initiated.
// - Bit 2 set when downstream bus not idle at switch.
// - Bit 1 set when built-in recovery sequence completes.
// - Bit 0 follows asserted downstream input; bits 5 and 4 read 0.
// - Status read clears flags 3, 2, 1 on the second clock pulse.
// - Read leaves test and downstream flags; those follow their sources.
`timescale 1ns/1ps
`include "dmi_consts.vh"
module dmi_irq_logic (
  input  wire       sys_clk,            // System clock, 100 MHz
  input  wire       reset_n,            // Asynchronous reset, active low
  input  wire [3:0] addr_pins,          // Slave address pins
  input  wire [1:0] scl_in,             // Upstream clock line, per master
  input  wire [1:0] sda_in,             // Upstream data line level
  output wire [1:0] sda_out,            // Upstream data drive value
  output wire [1:0] sda_oe,             // Upstream data drive enable
  input  wire       ds_scl_in,          // Downstream clock line
  input  wire       ds_sda_in,          // Downstream data line
  input  wire       ds_irq_n,           // Downstream interrupt, active low
  input  wire [1:0] lost_control_mask,  // Per master mask bits
  input  wire [1:0] recovery_done_mask, // Per master mask bits
  input  wire [1:0] bus_sensor_mask,    // Per master mask bits
  input  wire [1:0] downstream_irq_mask,// Per master mask bits
  input  wire [1:0] recovery_init,      // Per master recovery request
  input  wire [1:0] self_test_request,  // Per master self-test request
  input  wire [1:0] peer_test_request,  // Per master peer-test request
  input  wire [1:0] switch_pulse,       // Downstream handed to master
  input  wire [1:0] disconnect_pulse,   // Master cut off by the other
  input  wire [1:0] recovery_done_pulse,// Recovery done for new master
  output wire       master0_irq_out,    // Interrupt 0 drive value
  output wire       master0_irq_oe,     // Interrupt 0 drive enable
  output wire       master1_irq_out,    // Interrupt 1 drive value
  output wire       master1_irq_oe,     // Interrupt 1 drive enable
  output wire [7:0] irq_status0,        // Status register of master 0
  output wire [7:0] irq_status1         // Status register of master 1
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_CMD  = 3'h3;
  localparam [2:0] ST_READ = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  wire [`DMI_SYNC_WIDTH-1:0] raw_pins;
  wire [`DMI_SYNC_WIDTH-1:0] sync_pins;
  wire [1:0]                 s_scl;
  wire [1:0]                 s_sda;
  wire                       s_ds_scl;
  wire                       s_ds_sda;
  wire                       s_ds_irq_n;
  wire [3:0]                 s_addr;
  wire                       ds_busy;
  wire [1:0]                 irq_drive;
  wire [15:0]                status_flat;

  // All pins share the same two stages, so their relative timing holds
  assign raw_pins = {addr_pins, ds_irq_n, ds_sda_in, ds_scl_in,
                     sda_in, scl_in};

  dmi_sync #(
    .WIDTH     (`DMI_SYNC_WIDTH),
    .RESET_VAL (`DMI_SYNC_RESET)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );

  assign s_scl      = sync_pins[1:0];
  assign s_sda      = sync_pins[3:2];
  assign s_ds_scl   = sync_pins[4];
  assign s_ds_sda   = sync_pins[5];
  assign s_ds_irq_n = sync_pins[6];
  assign s_addr     = sync_pins[10:7];

  // Tracks START..STOP downstream at all times
  dmi_bus_sensor u_sensor (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .scl     (s_ds_scl),
    .sda     (s_ds_sda),
    .busy    (ds_busy)
  );

  genvar m;
  generate
    for (m = 0; m < 2; m = m + 1) begin : g_master
      localparam integer O = 1 - m;

      reg [2:0] state;
      reg [3:0] bit_cnt;
      reg [7:0] shift;
      reg [1:0] reg_sel;
      reg       rd_dir;
      reg       ack_of_cmd;
      reg       drive_low;
      reg       scl_prev;
      reg       sda_prev;
      reg       lost_flag;
      reg       unclean_flag;
      reg       rdone_flag;
      reg [7:0] status;
      reg       irq_active;
      reg [7:0] next_status;

      wire start_seen = s_scl[m] & scl_prev & sda_prev & ~s_sda[m];
      wire stop_seen  = s_scl[m] & scl_prev & ~sda_prev & s_sda[m];
      wire scl_rise   = s_scl[m] & ~scl_prev;
      wire scl_fall   = ~s_scl[m] & scl_prev;
      wire byte_done  = (bit_cnt == `DMI_BITS_PER_BYTE);
      wire addr_match = (shift[7:1] == {`DMI_ADDR_PREFIX, s_addr});
      wire sel_status = (reg_sel == `DMI_REG_STATUS);

      // Clear lands on the second clock rise of a status data byte
      wire read_clear = (state == ST_READ) & scl_rise & sel_status &
                        (bit_cnt == `DMI_CLEAR_PULSE);

      wire set_lost    = disconnect_pulse[m];
      wire set_unclean = switch_pulse[m] & ds_busy &
                         ~recovery_init[m];
      wire set_rdone   = recovery_done_pulse[m];
      wire ds_flag     = ~s_ds_irq_n;

      // Previous levels for edge and bus condition detection; reset to
      // the idle high level so no false START follows reset
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          scl_prev <= 1'b1;
          sda_prev <= 1'b1;
        end else begin
          scl_prev <= s_scl[m];
          sda_prev <= s_sda[m];
        end
      end

      // Other selects leave SDA alone; their data comes from the control
      // logic, whose drive is wire-ANDed with ours
      wire first_bit_low = sel_status & ~status[7];
      wire next_bit_low  = sel_status & ~shift[6];

      // Upstream read port: only the status register is served here
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          state      <= ST_IDLE;
          bit_cnt    <= 4'h0;
          shift      <= 8'h00;
          reg_sel    <= 2'b00;
          rd_dir     <= 1'b0;
          ack_of_cmd <= 1'b0;
          drive_low  <= 1'b0;
        end else begin
          if (stop_seen) begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
          end else if (start_seen) begin
            // Repeated start keeps the register select
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
          end else begin
            case (state)
              ST_ADDR, ST_CMD: begin
                if (scl_rise && !byte_done) begin
                  shift   <= {shift[6:0], s_sda[m]};
                  bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_fall && byte_done) begin
                  if (state == ST_CMD) begin
                    reg_sel    <= shift[`DMI_SEL_MSB:`DMI_SEL_LSB];
                    ack_of_cmd <= 1'b1;
                    drive_low  <= 1'b1;
                    state      <= ST_ACK;
                  end else if (addr_match) begin
                    rd_dir     <= shift[0];
                    ack_of_cmd <= 1'b0;
                    drive_low  <= 1'b1;
                    state      <= ST_ACK;
                  end else begin
                    state <= ST_SKIP;
                  end
                end
              end
              ST_ACK: begin
                if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (ack_of_cmd) begin
                    // Data bytes of a write belong to the control logic
                    drive_low <= 1'b0;
                    state     <= ST_SKIP;
                  end else if (rd_dir) begin
                    shift     <= status;
                    drive_low <= first_bit_low;
                    state     <= ST_READ;
                  end else begin
                    drive_low <= 1'b0;
                    state     <= ST_CMD;
                  end
                end
              end
              ST_READ: begin
                // SDA moves only after SCL falls, inside the low phase
                if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_fall) begin
                  if (byte_done) begin
                    drive_low <= 1'b0;
                    state     <= ST_RACK;
                  end else begin
                    shift     <= {shift[6:0], 1'b0};
                    drive_low <= next_bit_low;
                  end
                end
              end
              ST_RACK: begin
                if (scl_rise && s_sda[m]) begin
                  // Not acknowledged: master ends the read
                  state <= ST_SKIP;
                end else if (scl_fall) begin
                  bit_cnt   <= 4'h0;
                  shift     <= status;
                  drive_low <= first_bit_low;
                  state     <= ST_READ;
                end
              end
              ST_IDLE, ST_SKIP: begin
                drive_low <= 1'b0;
              end
              default: begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
              end
            endcase
          end
        end
      end

      // Sticky flags: a new event in the clearing cycle wins, so an
      // event that lands in the clearing cycle stays set for the next read
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          lost_flag    <= 1'b0;
          unclean_flag <= 1'b0;
          rdone_flag   <= 1'b0;
        end else begin
          if (set_lost) begin
            lost_flag <= 1'b1;
          end else if (read_clear) begin
            lost_flag <= 1'b0;
          end
          if (set_unclean) begin
            unclean_flag <= 1'b1;
          end else if (read_clear) begin
            unclean_flag <= 1'b0;
          end
          if (set_rdone) begin
            rdone_flag <= 1'b1;
          end else if (read_clear) begin
            rdone_flag <= 1'b0;
          end
        end
      end

      // One register per master, read only through its own port
      always @* begin
        next_status                     = `DMI_STATUS_RESET;
        next_status[`DMI_BIT_PEER_TEST] = peer_test_request[O];
        next_status[`DMI_BIT_SELF_TEST] = self_test_request[m];
        next_status[`DMI_BIT_LOST]      = lost_flag;
        next_status[`DMI_BIT_UNCLEAN]   = unclean_flag;
        next_status[`DMI_BIT_RDONE]     = rdone_flag;
        next_status[`DMI_BIT_DS_IRQ]    = ds_flag;
      end

      // Bits 5 and 4 keep the reset value and always read zero
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          status <= `DMI_STATUS_RESET;
        end else begin
          status <= next_status;
        end
      end

      // Flags stay visible when masked; masks gate only the output
      wire src_lost    = lost_flag & ~lost_control_mask[m];
      wire src_rdone   = rdone_flag & ~recovery_done_mask[m];
      wire src_unclean = unclean_flag & ~bus_sensor_mask[m];
      wire src_ds      = ds_flag & ~downstream_irq_mask[m];
      wire src_self    = self_test_request[m];
      wire src_peer    = peer_test_request[O];
      wire next_irq    = src_lost | src_rdone | src_unclean | src_ds |
                         src_self | src_peer;

      // Registered so the pin cannot glitch while sources change together
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          irq_active <= 1'b0;
        end else begin
          irq_active <= next_irq;
        end
      end

      assign sda_out[m]             = 1'b0;
      assign sda_oe[m]              = drive_low;
      assign irq_drive[m]           = irq_active;
      assign status_flat[m*8 +: 8]  = status;
    end
  endgenerate

  // Open drain: the value is always low, only the enable moves
  assign master0_irq_out = 1'b0;
  assign master0_irq_oe  = irq_drive[0];
  assign master1_irq_out = 1'b0;
  assign master1_irq_oe  = irq_drive[1];

  assign irq_status0 = status_flat[7:0];
  assign irq_status1 = status_flat[15:8];

endmodule // dmi_irq_logic

// ---- dmi_irq_sva.sv ----
// Assertion checker for the dual master interrupt logic
`timescale 1ns/1ps
module dmi_irq_sva (
  input wire       sys_clk,             // Clock
  input wire       reset_n,             // Reset, active low
  input wire       ds_irq_n,            // Downstream interrupt
  input wire [1:0] lost_control_mask,   // Mask
  input wire [1:0] recovery_done_mask,  // Mask
  input wire [1:0] bus_sensor_mask,     // Mask
  input wire [1:0] downstream_irq_mask, // Mask
  input wire [1:0] recovery_init,       // Recovery request
  input wire [1:0] self_test_request,   // Test request
  input wire [1:0] peer_test_request,   // Test request
  input wire [1:0] switch_pulse,        // Switch event
  input wire [1:0] disconnect_pulse,    // Loss event
  input wire [1:0] recovery_done_pulse, // Recovery event
  input wire       master0_irq_out,     // Pin value 0
  input wire       master0_irq_oe,      // Pin enable 0
  input wire       master1_irq_out,     // Pin value 1
  input wire       master1_irq_oe,      // Pin enable 1
  input wire [7:0] irq_status0,         // Status 0
  input wire [7:0] irq_status1          // Status 1
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Masks reach the pin one cycle late, as flags reach the status bits
  logic [3:0] en0, en1;
  always @(posedge sys_clk) begin
    en0 <= ~{lost_control_mask[0], bus_sensor_mask[0],
             recovery_done_mask[0], downstream_irq_mask[0]};
    en1 <= ~{lost_control_mask[1], bus_sensor_mask[1],
             recovery_done_mask[1], downstream_irq_mask[1]};
  end
  sequence s_lost0;
    disconnect_pulse[0] && !lost_control_mask[0] ##1 !lost_control_mask[0];
  endsequence
  sequence s_ds_low;
    !ds_irq_n [*5];
  endsequence
  property p_lost_flag;
    disconnect_pulse[1] |-> ##2 irq_status1[3];
  endproperty
  property p_lost_irq;
    s_lost0 |-> ##1 master0_irq_oe;
  endproperty
  property p_self;
    self_test_request[0] |=> irq_status0[6] && master0_irq_oe;
  endproperty
  property p_peer;
    peer_test_request[0] |=> irq_status1[7] && master1_irq_oe;
  endproperty
  property p_fixed;
    irq_status0[5:4] == 2'h0 && irq_status1[5:4] == 2'h0;
  endproperty
  property p_open_drain;
    !master0_irq_out && !master1_irq_out;
  endproperty
  property p_or0;
    master0_irq_oe == |(irq_status0 & {4'hc, en0});
  endproperty
  property p_or1;
    master1_irq_oe == |(irq_status1 & {4'hc, en1});
  endproperty
  property p_unclean_rec;
    switch_pulse[1] && recovery_init[1] && !irq_status1[2] ##1
      !irq_status1[2] |=> !irq_status1[2];
  endproperty
  property p_rdone;
    recovery_done_pulse[1] |-> ##2 irq_status1[1];
  endproperty
  property p_ds;
    s_ds_low |-> irq_status0[0] && irq_status1[0];
  endproperty
  a_lost_flag: assert property (p_lost_flag)
    else $error("lost flag missing");
  a_lost_irq: assert property (p_lost_irq)
    else $error("lost interrupt missing");
  a_self: assert property (p_self)
    else $error("self test missing");
  a_peer: assert property (p_peer)
    else $error("peer test missing");
  a_fixed: assert property (p_fixed)
    else $error("unused bits set");
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  a_or0: assert property (p_or0)
    else $error("pin 0 mismatch");
  a_or1: assert property (p_or1)
    else $error("pin 1 mismatch");
  a_unclean_rec: assert property (p_unclean_rec)
    else $error("unclean flag with recovery");
  a_rdone: assert property (p_rdone)
    else $error("recovery flag missing");
  a_ds: assert property (p_ds)
    else $error("downstream flag missing");
endmodule // dmi_irq_sva

// ---- dmi_partner.sv ----
// Upstream masters and downstream bus lines seen by the block
`timescale 1ns/1ps
module dmi_partner #(
  parameter logic [3:0] ADDR = 4'h5
) (
  input  wire  [1:0] sda_oe,    // Device pulls data low
  output wire  [1:0] scl_in,    // Upstream clocks
  output wire  [1:0] sda_in,    // Resolved upstream data
  output logic       ds_scl_in, // Downstream clock
  output logic       ds_sda_in  // Downstream data
);
  logic [1:0] scl_d = 2'h3;
  logic [1:0] sda_d = 2'h3;
  assign scl_in = scl_d;
  // Pull-ups: a released line reads high
  assign sda_in = sda_d & ~sda_oe;
  initial begin
    ds_scl_in = 1'b1;
    ds_sda_in = 1'b1;
  end
  task automatic bit_x(input int m, input logic b, output logic r);
    sda_d[m] = b;
    #40 scl_d[m] = 1'b1;
    #40 r = sda_in[m];
    #40 scl_d[m] = 1'b0;
    #40;
  endtask
  task automatic byte_x(input int m, input logic [8:0] tx,
                        output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bit_x(m, tx[i], rx[i]);
  endtask
  task automatic read_status(input int m, input logic [1:0] sel,
                             output logic [7:0] d);
    logic [8:0] rx;
    sda_d[m] = 1'b0;
    #80 scl_d[m] = 1'b0;
    #40;
    byte_x(m, {3'h7, ADDR, 2'h1}, rx);
    byte_x(m, {6'h00, sel, 1'b1}, rx);
    sda_d[m] = 1'b1;
    #40 scl_d[m] = 1'b1;
    #40 sda_d[m] = 1'b0;
    #40 scl_d[m] = 1'b0;
    #40;
    byte_x(m, {3'h7, ADDR, 2'h3}, rx);
    byte_x(m, 9'h1ff, rx);
    d = rx[8:1];
    sda_d[m] = 1'b0;
    #40 scl_d[m] = 1'b1;
    #40 sda_d[m] = 1'b1;
    #40;
  endtask
  // Left mid-transfer on purpose so the sensor sees a busy bus
  task automatic ds_start();
    #40 ds_sda_in = 1'b0;
    #40 ds_scl_in = 1'b0;
  endtask
  task automatic ds_stop();
    #40 ds_scl_in = 1'b1;
    #40 ds_sda_in = 1'b1;
  endtask
endmodule // dmi_partner

// ---- dmi_sync.v ----
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module dmi_sync #(
  parameter                   WIDTH     = 11,
  parameter [WIDTH-1:0]       RESET_VAL = {WIDTH{1'b1}}
) (
  input  wire                 sys_clk,  // System clock
  input  wire                 reset_n,  // Asynchronous reset, active low
  input  wire [WIDTH-1:0]     async_in, // Raw pin levels
  output wire [WIDTH-1:0]     sync_out  // Levels after two stages
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // Idle bus lines are high, so reset to the idle level
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule // dmi_sync

// ---- tb_top.sv ----
// Self-checking testbench for the dual master interrupt logic
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] addr_pins = 4'h5;
  logic       ds_irq_n = 1'b1;
  logic [1:0] lost_control_mask = 2'h0, recovery_done_mask = 2'h0;
  logic [1:0] bus_sensor_mask = 2'h0, downstream_irq_mask = 2'h0;
  logic [1:0] recovery_init = 2'h0, self_test_request = 2'h0;
  logic [1:0] peer_test_request = 2'h0, switch_pulse = 2'h0;
  logic [1:0] disconnect_pulse = 2'h0, recovery_done_pulse = 2'h0;
  wire  [1:0] scl_in, sda_in, sda_out, sda_oe;
  wire        ds_scl_in, ds_sda_in;
  wire        master0_irq_out, master0_irq_oe;
  wire        master1_irq_out, master1_irq_oe;
  wire  [7:0] irq_status0, irq_status1;
  int         err_count = 0, num_checks = 0, cycles = 0;
  logic [7:0] rd;
  // {self, peer, status0[7:6], status1[7:6], oe1, oe0}
  logic [9:0] rows [6] = '{10'h111, 10'h206, 10'h04a, 10'h0a1,
                           10'h3ff, 10'h000};
  dmi_irq_logic i_dmi_irq_logic (.sys_clk, .reset_n, .addr_pins,
    .scl_in, .sda_in, .sda_out, .sda_oe, .ds_scl_in, .ds_sda_in,
    .ds_irq_n, .lost_control_mask, .recovery_done_mask, .bus_sensor_mask,
    .downstream_irq_mask, .recovery_init, .self_test_request,
    .peer_test_request, .switch_pulse, .disconnect_pulse,
    .recovery_done_pulse, .master0_irq_out, .master0_irq_oe,
    .master1_irq_out, .master1_irq_oe, .irq_status0, .irq_status1);
  dmi_partner i_dmi_partner (.sda_oe, .scl_in, .sda_in, .ds_scl_in,
    .ds_sda_in);
  always #5 sys_clk = ~sys_clk;
  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    cyc(4);
    reset_n = 1'b1;
    cyc(4);
    chk(irq_status0 | irq_status1, 8'h00);
    foreach (rows[i]) begin
      {self_test_request, peer_test_request} = rows[i][9:6];
      cyc(2);
      chk({irq_status0[7:6], irq_status1[7:6], 2'h0, master1_irq_oe,
           master0_irq_oe}, {rows[i][5:2], 2'h0, rows[i][1:0]});
    end
    downstream_irq_mask = 2'h1;
    ds_irq_n = 1'b0;
    cyc(5);
    chk({irq_status0[0], irq_status1[0], master0_irq_oe, master1_irq_oe},
        8'h0d);
    ds_irq_n = 1'b1;
    cyc(5);
    chk({irq_status0[0], irq_status1[0], master1_irq_oe}, 8'h00);
    downstream_irq_mask = 2'h0;
    disconnect_pulse = 2'h1;
    cyc(1);
    disconnect_pulse = 2'h0;
    cyc(3);
    chk({irq_status0[3], master0_irq_oe, irq_status1[3]}, 8'h06);
    self_test_request = 2'h1;
    i_dmi_partner.read_status(0, 2'h2, rd);
    cyc(4);
    chk(rd, 8'h48);
    chk(irq_status0, 8'h40);
    self_test_request = 2'h0;
    lost_control_mask = 2'h2;
    disconnect_pulse = 2'h2;
    cyc(1);
    disconnect_pulse = 2'h0;
    cyc(3);
    chk({irq_status1[3], master1_irq_oe}, 8'h02);
    i_dmi_partner.read_status(1, 2'h1, rd);
    cyc(4);
    chk(rd, 8'hff);
    chk(irq_status1, 8'h08);
    i_dmi_partner.read_status(1, 2'h2, rd);
    cyc(4);
    chk(rd, 8'h08);
    chk(irq_status1, 8'h00);
    i_dmi_partner.ds_start();
    cyc(4);
    recovery_init = 2'h2;
    switch_pulse = 2'h3;
    cyc(1);
    switch_pulse = 2'h0;
    cyc(3);
    chk({irq_status0[2], irq_status1[2], master0_irq_oe, master1_irq_oe},
        8'h0a);
    bus_sensor_mask = 2'h1;
    cyc(2);
    chk(master0_irq_oe, 8'h00);
    recovery_done_pulse = 2'h2;
    cyc(1);
    recovery_done_pulse = 2'h0;
    cyc(3);
    chk({irq_status1[1], master1_irq_oe}, 8'h03);
    recovery_done_mask = 2'h2;
    cyc(2);
    chk(master1_irq_oe, 8'h00);
    i_dmi_partner.ds_stop();
    reset_n = 1'b0;
    cyc(2);
    chk(irq_status0 | irq_status1, 8'h00);
    chk({4'h0, sda_out, master0_irq_out, master1_irq_out}, 8'h00);
    reset_n = 1'b1;
    cyc(4);
    end_sim();
  end
endmodule // tb_top
bind dmi_irq_logic dmi_irq_sva i_dmi_irq_sva (.sys_clk, .reset_n,
  .ds_irq_n, .lost_control_mask, .recovery_done_mask, .bus_sensor_mask,
  .downstream_irq_mask, .recovery_init, .self_test_request,
  .peer_test_request, .switch_pulse, .disconnect_pulse,
  .recovery_done_pulse, .master0_irq_out, .master0_irq_oe,
  .master1_irq_out, .master1_irq_oe, .irq_status0, .irq_status1);
